// File: hdl/rirq_sync.sv
// Two-stage synchroniser for a bundle of pin levels
`timescale 1ns/10ps
module rirq_sync #(
   parameter int WIDTH = 5,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } rirq_sync_st_t;

   rirq_sync_st_t st_r;
   rirq_sync_st_t st_nxt;

   generate
      if (WIDTH < 1) begin : g_chk
         $error("rirq_sync WIDTH must be at least 1");
      end
   endgenerate

   // First stage is read by the second stage only
   always_comb begin
      st_nxt.meta = pin_in;
      st_nxt.stable = st_r.meta;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_r <= {RST_VAL, RST_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.stable;
endmodule : rirq_sync

// File: hdl/rirq_tick.sv
// Oscillator prescaler: 1024 Hz and 1 Hz square waves and the second tick
`timescale 1ns/10ps
`include "rirq_map.svh"
module rirq_tick #(
   parameter int OSC_HZ = `RIRQ_OSC_HZ
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic osc_lvl,
   input wire logic run,
   output logic clk_1k,
   output logic clk_1hz,
   output logic sec_tick
);
   localparam int CW = $clog2(OSC_HZ);
   localparam int B1K = $clog2(OSC_HZ / 1024) - 1;

   typedef struct packed {
      logic osc_prev;
      logic [CW-1:0] cnt;
      logic sec;
   } rirq_tick_st_t;

   rirq_tick_st_t st_r;
   rirq_tick_st_t st_nxt;

   generate
      if (OSC_HZ < 2048 || (OSC_HZ & (OSC_HZ - 1)) != 0) begin : g_chk
         $error("rirq_tick OSC_HZ must be a power of two of at least 2048");
      end
   endgenerate

   always_comb begin
      st_nxt = st_r;
      st_nxt.osc_prev = osc_lvl;
      st_nxt.sec = 1'b0;
      if (osc_lvl && !st_r.osc_prev) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
         // Timekeeping halted: prescaler runs on, but no second passes
         st_nxt.sec = run && (&st_r.cnt);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign clk_1k = st_r.cnt[B1K];
   assign clk_1hz = st_r.cnt[CW-1];
   assign sec_tick = st_r.sec;
endmodule : rirq_tick

// File: hdl/rirq_top.sv
// Update interrupt, oscillation stop flag, clock output and backup control
`timescale 1ns/10ps
`include "rirq_map.svh"
module rirq_top
   import rirq_pkg::*;
#(
   parameter int UPD_PULSE_CYC = `RIRQ_UPD_PULSE_CYC,
   parameter int OSC_HZ = `RIRQ_OSC_HZ
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic osc_clk_pin,
   input wire logic osc_stop_pin,
   input wire logic below_reset_pin,
   input wire logic below_switch_pin,
   input wire logic other_irq_n_pin,
   output logic irq_n_o,
   output logic irq_n_oe,
   output logic clkout_pin_o,
   output logic clkout_pin_oe,
   output logic serial_if_enable,
   output logic backup_mode,
   output logic main_supply_switch,
   output logic charge_switch_a,
   output logic charge_switch_b
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   generate
      if (UPD_PULSE_CYC < 1 || UPD_PULSE_CYC > 24'hFFFFFF) begin : g_chk
         $error("rirq_top UPD_PULSE_CYC out of range");
      end
   endgenerate

   localparam logic [23:0] PULSE_LAST = 24'(UPD_PULSE_CYC - 1);

   // ----------------------------------------------------------------
   // Pin synchronisers and prescaler
   // ----------------------------------------------------------------
   rirq_pins_t pins;
   logic clk_1k;
   logic clk_1hz;
   logic sec_tick;
   rirq_state_t st_r;
   rirq_state_t st_nxt;

   rirq_sync #(
      .WIDTH(5),
      .RST_VAL(5'h01)
   ) u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pin_in({osc_clk_pin, osc_stop_pin, below_reset_pin, below_switch_pin,
               other_irq_n_pin}),
      .sync_out(pins)
   );

   rirq_tick #(
      .OSC_HZ(OSC_HZ)
   ) u_tick (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .osc_lvl(pins.osc),
      .run(!st_r.ctrl[`RIRQ_CTRL_STOP]),
      .clk_1k(clk_1k),
      .clk_1hz(clk_1hz),
      .sec_tick(sec_tick)
   );

   // ----------------------------------------------------------------
   // Register decode helpers
   // ----------------------------------------------------------------
   function automatic logic reg_mapped(input logic [31:0] a);
      logic hit;
      hit = (a[31:8] == 24'h000000) && (a[1:0] == 2'h0);
      case (a[7:2])
         `RIRQ_IDX_EXT_CFG, `RIRQ_IDX_FLAGS, `RIRQ_IDX_CTRL, `RIRQ_IDX_PWR: begin
            reg_mapped = hit;
         end
         default: begin
            reg_mapped = 1'b0;
         end
      endcase
   endfunction : reg_mapped

   function automatic logic [31:0] reg_read(input logic [5:0] idx,
                                            input rirq_state_t s);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         `RIRQ_IDX_EXT_CFG: begin
            v = s.ext_cfg;
         end
         `RIRQ_IDX_FLAGS: begin
            v[`RIRQ_FLG_UPD] = s.upd_flag;
            v[`RIRQ_FLG_OSF] = s.osf;
         end
         `RIRQ_IDX_CTRL: begin
            v = s.ctrl;
         end
         `RIRQ_IDX_PWR: begin
            v = s.pwr;
         end
         default: begin
            v = 8'h00;
         end
      endcase
      reg_read = {24'h000000, v};
   endfunction : reg_read

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic addr_ph;
   logic upd_event;
   logic wr_flags;
   rirq_fsel_t fsel;

   always_comb begin
      st_nxt = st_r;
      addr_ph = hsel && hready && htrans[1];
      wr_flags = st_r.dp_wr && (st_r.dp_idx == `RIRQ_IDX_FLAGS);

      // Register writes land in the data phase
      if (st_r.dp_wr) begin
         unique case (st_r.dp_idx)
            `RIRQ_IDX_EXT_CFG: begin
               st_nxt.ext_cfg = hwdata[7:0];
            end
            `RIRQ_IDX_CTRL: begin
               st_nxt.ctrl = hwdata[7:0];
            end
            `RIRQ_IDX_PWR: begin
               st_nxt.pwr = hwdata[7:0];
               st_nxt.pwr[`RIRQ_PWR_ZERO] = 1'b0;
            end
            default: begin
            end
         endcase
      end

      // Second counter for the minute update period
      upd_event = 1'b0;
      if (sec_tick) begin
         if (st_r.sec_cnt == `RIRQ_SEC_PER_MIN) begin
            st_nxt.sec_cnt = 6'h00;
         end else begin
            st_nxt.sec_cnt = st_r.sec_cnt + 6'h01;
         end
         // Seconds are counted in both modes, so a mode change keeps its phase
         upd_event = !st_r.ext_cfg[`RIRQ_EXT_PERIOD_SEL] ||
                     (st_r.sec_cnt == `RIRQ_SEC_PER_MIN);
      end

      // Flags: write 0 clears, write 1 ignored, a new event wins
      if (wr_flags && !hwdata[`RIRQ_FLG_UPD]) begin
         st_nxt.upd_flag = 1'b0;
      end
      if (upd_event) begin
         st_nxt.upd_flag = 1'b1;
      end
      if (wr_flags && !hwdata[`RIRQ_FLG_OSF]) begin
         st_nxt.osf = 1'b0;
      end
      if (pins.osc_stopped) begin
         st_nxt.osf = 1'b1;
      end

      // Update interrupt low window, counted down from the event
      if (st_r.upd_act) begin
         if (st_r.upd_cnt == 24'h000000) begin
            st_nxt.upd_act = 1'b0;
         end else begin
            st_nxt.upd_cnt = st_r.upd_cnt - 24'h000001;
         end
      end
      // Clearing the flag also ends a pending low
      if (wr_flags && !hwdata[`RIRQ_FLG_UPD]) begin
         st_nxt.upd_act = 1'b0;
      end
      if (upd_event && st_nxt.ctrl[`RIRQ_CTRL_UPD_IRQ_EN]) begin
         st_nxt.upd_act = 1'b1;
         st_nxt.upd_cnt = PULSE_LAST;
      end
      if (!st_nxt.ctrl[`RIRQ_CTRL_UPD_IRQ_EN]) begin
         st_nxt.upd_act = 1'b0;
      end
      // Shared open-drain line; other sources ignore the update enable
      st_nxt.irq_oe = st_nxt.upd_act || !pins.other_irq_n;

      // Supply mode and switches
      st_nxt.backup = pins.below_switch;
      st_nxt.sw_main = !pins.below_switch;
      // Charging needs both enables; init detect off behaves as no charge
      st_nxt.sw_a = !pins.below_switch && st_nxt.pwr[`RIRQ_PWR_CHARGE_EN] &&
                    st_nxt.pwr[`RIRQ_PWR_INIT_DET_EN];
      st_nxt.sw_b = st_nxt.sw_a;
      // Serial port survives a below-reset supply unless init detect is set; a below-switch supply always stops it
      // Limitation: the supply level is only seen after two flops
      st_nxt.ser_en = !pins.below_switch &&
                      !(st_nxt.pwr[`RIRQ_PWR_INIT_DET_EN] && pins.below_reset);

      // Clock output
      fsel = rirq_fsel_t'(st_nxt.ext_cfg[`RIRQ_EXT_FSEL_HI:`RIRQ_EXT_FSEL_LO]);
      unique case (fsel)
         RIRQ_CKO_32K: begin
            st_nxt.clk_o = pins.osc;
         end
         RIRQ_CKO_1K: begin
            st_nxt.clk_o = clk_1k;
         end
         RIRQ_CKO_1HZ: begin
            st_nxt.clk_o = clk_1hz && !st_nxt.ctrl[`RIRQ_CTRL_STOP];
         end
         RIRQ_CKO_OFF: begin
            // Parked low; the pin is floated by clk_oe, so this level never reaches it
            st_nxt.clk_o = 1'b0;
         end
      endcase
      st_nxt.clk_oe = (fsel != RIRQ_CKO_OFF) && !pins.below_reset &&
                      !pins.below_switch;

      // Bus: zero-wait slave; read data taken from post-write values
      st_nxt.hreadyout = 1'b1;
      if (hready) begin
         st_nxt.dp_wr = addr_ph && hwrite && reg_mapped(haddr);
         st_nxt.dp_idx = haddr[7:2];
         if (addr_ph && !hwrite && reg_mapped(haddr)) begin
            st_nxt.hrdata = reg_read(haddr[7:2], st_nxt);
         end else begin
            st_nxt.hrdata = 32'h00000000;
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.ext_cfg <= `RIRQ_RST_EXT_CFG;
         st_r.ctrl <= `RIRQ_RST_CTRL;
         st_r.pwr <= `RIRQ_RST_PWR;
         st_r.osf <= `RIRQ_RST_OSF;
         st_r.hreadyout <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign hreadyout = st_r.hreadyout;
   assign hrdata = st_r.hrdata;
   // Only OKAY is ever answered
   assign hresp = 1'b0;
   assign irq_n_o = 1'b0;
   assign irq_n_oe = st_r.irq_oe;
   assign clkout_pin_o = st_r.clk_o;
   assign clkout_pin_oe = st_r.clk_oe;
   assign serial_if_enable = st_r.ser_en;
   assign backup_mode = st_r.backup;
   assign main_supply_switch = st_r.sw_main;
   assign charge_switch_a = st_r.sw_a;
   assign charge_switch_b = st_r.sw_b;

endmodule : rirq_top

// File: inc/rirq_map.svh
// Register indices, field positions, reset values and timing figures
`ifndef RIRQ_MAP_SVH
`define RIRQ_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RIRQ_IDX_EXT_CFG 6'h1C
`define RIRQ_IDX_FLAGS 6'h1D
`define RIRQ_IDX_CTRL 6'h1E
`define RIRQ_IDX_PWR 6'h1F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RIRQ_EXT_FSEL_HI 7
`define RIRQ_EXT_FSEL_LO 6
`define RIRQ_EXT_PERIOD_SEL 5
`define RIRQ_FLG_UPD 5
`define RIRQ_FLG_OSF 1
`define RIRQ_CTRL_STOP 6
`define RIRQ_CTRL_UPD_IRQ_EN 5
`define RIRQ_PWR_CHARGE_EN 5
`define RIRQ_PWR_INIT_DET_EN 4
`define RIRQ_PWR_ZERO 3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RIRQ_RST_EXT_CFG 8'h00
`define RIRQ_RST_CTRL 8'h00
`define RIRQ_RST_PWR 8'h00
`define RIRQ_RST_OSF 1'b1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RIRQ_CLK_NS 20
`define RIRQ_UPD_PULSE_US 7570
`define RIRQ_UPD_PULSE_CYC ((`RIRQ_UPD_PULSE_US * 1000 + `RIRQ_CLK_NS - 1) / `RIRQ_CLK_NS)
`define RIRQ_OSC_HZ 32768
`define RIRQ_SEC_PER_MIN 6'h3B

`endif

// File: inc/rirq_pkg.sv
// Types shared by the clock control slice
package rirq_pkg;

   typedef enum logic [1:0] {
      RIRQ_CKO_32K = 2'h0,
      RIRQ_CKO_1K = 2'h1,
      RIRQ_CKO_1HZ = 2'h2,
      RIRQ_CKO_OFF = 2'h3
   } rirq_fsel_t;

   typedef struct packed {
      logic osc;
      logic osc_stopped;
      logic below_reset;
      logic below_switch;
      logic other_irq_n;
   } rirq_pins_t;

   typedef struct packed {
      logic [7:0] ext_cfg;
      logic [7:0] ctrl;
      logic [7:0] pwr;
      logic upd_flag;
      logic osf;
      logic upd_act;
      logic [23:0] upd_cnt;
      logic [5:0] sec_cnt;
      logic dp_wr;
      logic [5:0] dp_idx;
      logic [31:0] hrdata;
      logic hreadyout;
      logic irq_oe;
      logic clk_o;
      logic clk_oe;
      logic ser_en;
      logic backup;
      logic sw_main;
      logic sw_a;
      logic sw_b;
   } rirq_state_t;

endpackage : rirq_pkg

// File: tb/rirq_host_model.sv
// Host side model: resolves irq and clock pins, counts their activity
`timescale 1ns/10ps
module rirq_host_model (
   input wire logic ref_clk,
   input wire logic cnt_clr,
   input wire logic irq_n_o,
   input wire logic irq_n_oe,
   input wire logic clk_o,
   input wire logic clk_oe,
   output logic irq_line,
   output logic clk_line,
   output logic [7:0] irq_cnt,
   output logic [15:0] clk_cnt
);
   logic irq_p = 1'b1;
   logic clk_p = 1'b0;
   logic last = 1'b0;
   assign irq_line = irq_n_oe ? irq_n_o : 1'b1;
   // Floating clock pin shows the inverse, never a stale level
   assign clk_line = clk_oe ? clk_o : ~last;
   always @(posedge ref_clk) begin
      irq_p <= irq_line;
      clk_p <= clk_line;
      if (clk_oe) last <= clk_o;
      irq_cnt <= cnt_clr ? 8'h00 : irq_cnt + {7'h00, irq_p & ~irq_line};
      clk_cnt <= cnt_clr ? 16'h0000 : clk_cnt + {15'h0000, clk_oe & (clk_p ^ clk_line)};
   end
endmodule : rirq_host_model

// File: tb/rirq_top_monitor.sv
// Checker for the clock control slice ports
`timescale 1ns/10ps
module rirq_top_monitor #(
   parameter int UPD_PULSE_CYC = 20
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic other_irq_n_pin,
   input wire logic below_reset_pin,
   input wire logic below_switch_pin,
   input wire logic irq_n_o,
   input wire logic irq_n_oe,
   input wire logic clkout_pin_oe,
   input wire logic serial_if_enable,
   input wire logic backup_mode,
   input wire logic charge_switch_a,
   input wire logic charge_switch_b
);
   // ------------------------------
   // Helpers
   // ------------------------------
   logic [23:0] hi_c;
   logic [4:0] wq;
   logic [4:0] oq;
   // Recent writes or another source's release excuse an early release
   always_ff @(posedge ref_clk) begin
      hi_c <= irq_n_oe ? hi_c + 24'h1 : 24'h0;
      wq <= {wq[3:0], hsel & htrans[1] & hwrite & hready};
      oq <= {oq[3:0], !other_irq_n_pin};
   end
   // ------------------------------
   // Properties
   // ------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_oth_low; !other_irq_n_pin [*5]; endsequence
   sequence s_bk; below_switch_pin [*5]; endsequence
   property p_rdy; hreadyout && !hresp; endproperty
   a_rdy: assert property (p_rdy) else $error("bus stall or error");
   property p_od; irq_n_o == 1'b0; endproperty
   a_od: assert property (p_od) else $error("irq data not low");
   property p_min;
      $fell(irq_n_oe) && other_irq_n_pin && oq == 5'h0 && wq == 5'h0 |->
         hi_c >= UPD_PULSE_CYC;
   endproperty
   a_min: assert property (p_min) else $error("irq low too short");
   property p_max;
      irq_n_oe && other_irq_n_pin && $past(other_irq_n_pin, 4) |-> hi_c <= UPD_PULSE_CYC + 4;
   endproperty
   a_max: assert property (p_max) else $error("irq low too long");
   property p_oth; s_oth_low |-> irq_n_oe; endproperty
   a_oth: assert property (p_oth) else $error("other irq lost");
   property p_bk; s_bk |-> backup_mode && !serial_if_enable && !clkout_pin_oe; endproperty
   a_bk: assert property (p_bk) else $error("backup gating wrong");
   property p_nrm; !below_switch_pin [*5] |-> !backup_mode; endproperty
   a_nrm: assert property (p_nrm) else $error("backup without cause");
   property p_rst; below_reset_pin [*5] |-> !clkout_pin_oe; endproperty
   a_rst: assert property (p_rst) else $error("clock out not floated");
   property p_chg; backup_mode |-> !charge_switch_a && !charge_switch_b; endproperty
   a_chg: assert property (p_chg) else $error("charging in backup");
endmodule : rirq_top_monitor

bind rirq_top rirq_top_monitor #(.UPD_PULSE_CYC(UPD_PULSE_CYC)) u_mon (
   .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .other_irq_n_pin(other_irq_n_pin),
   .below_reset_pin(below_reset_pin), .below_switch_pin(below_switch_pin),
   .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .clkout_pin_oe(clkout_pin_oe),
   .serial_if_enable(serial_if_enable), .backup_mode(backup_mode),
   .charge_switch_a(charge_switch_a), .charge_switch_b(charge_switch_b));

// File: tb/rirq_top_tb.sv
// Self-checking bench for the clock control slice
`timescale 1ns/10ps
module rirq_top_tb;
   import rirq_pkg::*;
   logic ref_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, cnt_clr = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, obs = 32'h0, rs = 32'hD;
   logic [1:0] htrans = 2'h0, oc = 2'h0;
   logic osc_stop = 1'b0, bl_rst = 1'b0, bl_sw = 1'b0, oth_n = 1'b1, obs_v = 1'b0, dph = 1'b0;
   logic hreadyout, hresp, irq_o, irq_oe, ck_o, ck_oe, ser, bk, sw_m, sw_a, sw_b, irq_l, ck_l;
   logic [7:0] irq_cnt;
   logic [15:0] clk_cnt;
   logic [31:0] q[$];
   int err_count = 0, n_compared = 0, cyc = 0, st, c;
   logic ok;
   always #10 ref_clk = ~ref_clk;
   // --------------------------------
   // Design and host side
   // --------------------------------
   rirq_top #(.UPD_PULSE_CYC(200), .OSC_HZ(2048)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .osc_clk_pin(oc[1]), .osc_stop_pin(osc_stop), .below_reset_pin(bl_rst),
      .below_switch_pin(bl_sw), .other_irq_n_pin(oth_n), .irq_n_o(irq_o), .irq_n_oe(irq_oe),
      .clkout_pin_o(ck_o), .clkout_pin_oe(ck_oe), .serial_if_enable(ser),
      .backup_mode(bk), .main_supply_switch(sw_m), .charge_switch_a(sw_a),
      .charge_switch_b(sw_b));
   rirq_host_model host (.ref_clk(ref_clk), .cnt_clr(cnt_clr), .irq_n_o(irq_o),
      .irq_n_oe(irq_oe), .clk_o(ck_o), .clk_oe(ck_oe), .irq_line(irq_l), .clk_line(ck_l),
      .irq_cnt(irq_cnt), .clk_cnt(clk_cnt));
   // --------------------------------
   // Tasks
   // --------------------------------
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction : xs
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out
   // Whole-word transfer; holds each phase until hready is seen high
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
   endtask : xfer
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask : rd
   task automatic look(input logic [31:0] e, input logic [31:0] g);
      @(posedge ref_clk);
      q.push_back(e);
      obs <= g;
      obs_v <= 1'b1;
      @(posedge ref_clk);
      obs_v <= 1'b0;
   endtask : look
   task automatic pins(input logic [31:0] e);
      look(e, {25'h0, irq_oe, ck_oe, ser, bk, sw_m, sw_a, sw_b});
   endtask : pins
   task automatic wait_oe(input logic v);
      int k;
      k = 0;
      while (irq_oe !== v && k < 9500) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      if (k >= 9500) begin
         err_count++;
         $display("BAD t=%0t exp=%h got=%h", $time, v, irq_oe);
      end
   endtask : wait_oe
   task automatic cmp(input logic [31:0] g);
      logic [31:0] e;
      e = q.pop_front();
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp
   // --------------------------------
   // Watcher, oscillator, timeout
   // --------------------------------
   always @(posedge ref_clk) begin
      oc <= oc + 2'h1;
      if (dph && hreadyout === 1'b1) cmp(hrdata);
      if (obs_v) cmp(obs);
      dph <= (hsel && htrans[1] && hreadyout && !hwrite) ? 1'b1 : (hreadyout ? 1'b0 : dph);
      cyc++;
      if (cyc == 80000) begin
         err_count++;
         close_out();
      end
   end
   // --------------------------------
   // Main sequence
   // --------------------------------
   initial begin
      tick(12);
      reset_n <= 1'b1;
      rd(32'h70, 32'h0);
      rd(32'h74, 32'h2);
      rd(32'h78, 32'h0);
      rd(32'h7C, 32'h0);
      rd(32'h80, 32'h0);
      pins(32'h34);
      wr(32'h74, 32'hFF);
      rd(32'h74, 32'h2);
      wr(32'h74, 32'h0);
      rd(32'h74, 32'h0);
      repeat (4) begin
         c = xs() & 32'h1F;
         wr(32'h70, c);
         rd(32'h70, c);
      end
      wr(32'h70, 32'h0);
      osc_stop <= 1'b1;
      tick(6);
      osc_stop <= 1'b0;
      rd(32'h74, 32'h2);
      wr(32'h74, 32'h0);
      wr(32'h78, 32'h20);
      wait_oe(1'b1);
      rd(32'h74, 32'h20);
      wait_oe(1'b0);
      wr(32'h74, 32'h20);
      rd(32'h74, 32'h20);
      wr(32'h74, 32'h0);
      rd(32'h74, 32'h0);
      wait_oe(1'b1);
      wr(32'h78, 32'h0);
      tick(3);
      pins(32'h34);
      wr(32'h74, 32'h0);
      cnt_clr <= 1'b1;
      tick(1);
      cnt_clr <= 1'b0;
      tick(9000);
      rd(32'h74, 32'h20);
      look(32'h0, irq_cnt);
      wr(32'h78, 32'h40);
      wr(32'h74, 32'h0);
      tick(9000);
      rd(32'h74, 32'h0);
      for (st = 1; st >= 0; st--) begin
         for (c = 0; c < 4; c++) begin
            wr(32'h78, st << 6);
            wr(32'h70, c << 6);
            cnt_clr <= 1'b1;
            tick(1);
            cnt_clr <= 1'b0;
            tick(600);
            ok = (c == 0) ? clk_cnt > 200 : (c == 1) ? (clk_cnt > 0 && clk_cnt <= 200) :
               (c == 2 && st == 0) ? clk_cnt <= 1 : clk_cnt == 0;
            look(32'h1, ok);
         end
      end
      wr(32'h78, 32'h0);
      wr(32'h70, 32'h20);
      wr(32'h7C, 32'h30);
      tick(4);
      pins(32'h37);
      bl_sw <= 1'b1;
      tick(8);
      pins(32'h08);
      bl_sw <= 1'b0;
      tick(8);
      pins(32'h37);
      wr(32'h7C, 32'h10);
      tick(4);
      pins(32'h34);
      bl_rst <= 1'b1;
      tick(8);
      pins(32'h04);
      bl_rst <= 1'b0;
      oth_n <= 1'b0;
      tick(8);
      pins(32'h74);
      oth_n <= 1'b1;
      wr(32'h7C, 32'hFF);
      rd(32'h7C, 32'hF7);
      wr(32'h74, 32'h0);
      tick(9000);
      rd(32'h74, 32'h0);
      close_out();
   end
endmodule : rirq_top_tb
